/* rtl/cqm_pkg.sv */
// shared constants, types and helpers of the complex quadrature modulator
package cqm_pkg;

	localparam int CQM_DW = 14;
	localparam int CQM_CW = 16;
	localparam int CQM_FRAC = 14;

	localparam logic [7:0] CQM_CTRL_OFS = 8'h04;
	localparam logic [7:0] CQM_STAT_OFS = 8'h08;

	localparam int CQM_NEG_BIT = 1;
	localparam int CQM_MIX_BIT = 2;
	localparam int CQM_STUFF_BIT = 3;
	localparam int CQM_FREQ_LSB = 4;
	localparam int CQM_SAT_BIT = 0;
	localparam int CQM_SLOT_BIT = 1;
	localparam int CQM_PHASE_LSB = 4;

	localparam logic [5:0] CQM_CTRL_RST = 6'h00;
	localparam logic [2:0] CQM_PHASE_RST = 3'h0;

	localparam logic signed [CQM_CW-1:0] CQM_ONE = 16'sh4000;
	localparam logic signed [CQM_CW-1:0] CQM_R2 = 16'sh2d41;
	localparam logic signed [CQM_DW-1:0] CQM_MAX = 14'sh1fff;
	localparam logic signed [CQM_DW-1:0] CQM_MIN = -14'sh2000;

	typedef enum logic [1:0] {CQM_MOD_OFF, CQM_MOD_HALF, CQM_MOD_QUARTER, CQM_MOD_EIGHTH} cqm_freq_e;

	typedef struct packed {
		logic stuff_en;
		cqm_freq_e freq;
		logic mix;
		logic neg;
	} cqm_ctrl_s;

	typedef struct packed {
		logic signed [CQM_DW-1:0] re;
		logic signed [CQM_DW-1:0] im;
	} cqm_iq_s;

	typedef struct packed {
		cqm_iq_s y;
		logic sat;
	} cqm_mul_st_s;

	typedef struct packed {
		cqm_ctrl_s ctrl;
		logic [2:0] phase;
		logic slot;
		logic sat_sticky;
	} cqm_top_st_s;

	// cosine table over eight phase steps
	function automatic logic signed [CQM_CW-1:0] cqm_cos8(input logic [2:0] ph);
		logic signed [CQM_CW-1:0] c;
		c = '0;
		unique case (ph)
			3'h0: c = CQM_ONE;
			3'h1: c = CQM_R2;
			3'h2: c = '0;
			3'h3: c = -CQM_R2;
			3'h4: c = -CQM_ONE;
			3'h5: c = -CQM_R2;
			3'h6: c = '0;
			3'h7: c = CQM_R2;
		endcase
		return c;
	endfunction : cqm_cos8

	// phase advance per input sample taken, stuffed slots excluded
	function automatic logic [2:0] cqm_step(input cqm_freq_e f);
		logic [2:0] s;
		s = 3'h0;
		unique case (f)
			CQM_MOD_OFF: s = 3'h0;
			CQM_MOD_HALF: s = 3'h4;
			CQM_MOD_QUARTER: s = 3'h2;
			CQM_MOD_EIGHTH: s = 3'h1;
		endcase
		return s;
	endfunction : cqm_step

	// scale back and clamp to the output word; msb flags a clamp
	function automatic logic [CQM_DW:0] cqm_sat(input logic signed [30:0] v);
		logic signed [16:0] t;
		logic [CQM_DW:0] r;
		t = v[30:CQM_FRAC];
		if (t > 17'sh01fff) begin
			r = {1'b1, CQM_MAX};
		end else if (t < -17'sh02000) begin
			r = {1'b1, CQM_MIN};
		end else begin
			r = {1'b0, t[CQM_DW-1:0]};
		end
		return r;
	endfunction : cqm_sat

endpackage : cqm_pkg

/* rtl/cqm_cmul.sv */
// saturating complex multiplier with registered output
`timescale 1ns/1ps
`default_nettype none
module cqm_cmul
	import cqm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire cqm_iq_s in_s,
	input wire logic signed [CQM_CW-1:0] cos_c,
	input wire logic signed [CQM_CW-1:0] sin_c,
	input wire logic mix,
	input wire logic blank,
	output cqm_iq_s out_s,
	output logic sat
);
	cqm_mul_st_s st_r;
	cqm_mul_st_s st_nxt;
	logic signed [29:0] p_ic;
	logic signed [29:0] p_qs;
	logic signed [29:0] p_is;
	logic signed [29:0] p_qc;
	logic signed [30:0] s_re;
	logic signed [30:0] s_im;
	logic [CQM_DW:0] c_re;
	logic [CQM_DW:0] c_im;

	always_comb begin
		p_ic = in_s.re * cos_c;
		p_qs = in_s.im * sin_c;
		p_is = in_s.re * sin_c;
		p_qc = in_s.im * cos_c;
		if (mix) begin
			s_re = 31'(p_ic) - 31'(p_qs);
			s_im = 31'(p_is) + 31'(p_qc);
		end else begin
			s_re = 31'(p_ic);
			s_im = 31'(p_qc);
		end
		c_re = cqm_sat(s_re);
		c_im = cqm_sat(s_im);
		st_nxt = st_r;
		st_nxt.y.re = c_re[CQM_DW-1:0];
		st_nxt.y.im = c_im[CQM_DW-1:0];
		st_nxt.sat = c_re[CQM_DW] | c_im[CQM_DW];
		if (blank) begin
			st_nxt.y = '0;
			st_nxt.sat = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign out_s = st_r.y;
	assign sat = st_r.sat;
endmodule : cqm_cmul
`default_nettype wire

/* rtl/cqm_mod.sv */
// complex quadrature modulator with apb control
// Notes on behaviour
// - mix bit set joins both channel modulators into one complex modulation
// - sign bit picks positive or negative exponent carrier
// - carrier rate programmable to half, quarter or eighth of sample rate
// - carrier built from quadrature cosine and sine, applied as complex product when mix is set
// - complex mode flagged invalid only at half rate
// - same carrier whichever channels carry data
// - real and imaginary streams, one per dac channel
// - rate held in control bits five and four, after interpolation
// - midscale stuffing happens after the modulator output
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cqm_mod
	import cqm_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire cqm_iq_s SAMPLE_IN,
	output logic SAMPLE_READY,
	output cqm_iq_s SAMPLE_OUT,
	output logic COMPLEX_INVALID
);
	cqm_top_st_s st_r;
	cqm_top_st_s st_nxt;
	logic wr_ctrl;
	logic wr_stat;
	logic hit;
	logic sat_pulse;
	logic signed [CQM_CW-1:0] cos_c;
	logic signed [CQM_CW-1:0] sin_raw;
	logic signed [CQM_CW-1:0] sin_c;

	// control word to fields
	function automatic cqm_ctrl_s ctrl_of(input logic [31:0] w);
		cqm_ctrl_s c;
		c.neg = w[CQM_NEG_BIT];
		c.mix = w[CQM_MIX_BIT];
		c.stuff_en = w[CQM_STUFF_BIT];
		c.freq = cqm_freq_e'(w[CQM_FREQ_LSB+1:CQM_FREQ_LSB]);
		return c;
	endfunction : ctrl_of

	assign hit = (PADDR == CQM_CTRL_OFS) || (PADDR == CQM_STAT_OFS);
	assign wr_ctrl = PSEL && PENABLE && PWRITE && (PADDR == CQM_CTRL_OFS);
	assign wr_stat = PSEL && PENABLE && PWRITE && (PADDR == CQM_STAT_OFS);
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !hit;

	always_comb begin
		PRDATA = 32'h0;
		if (PSEL && PENABLE && !PWRITE) begin
			if (PADDR == CQM_CTRL_OFS) begin
				PRDATA[CQM_NEG_BIT] = st_r.ctrl.neg;
				PRDATA[CQM_MIX_BIT] = st_r.ctrl.mix;
				PRDATA[CQM_STUFF_BIT] = st_r.ctrl.stuff_en;
				PRDATA[CQM_FREQ_LSB+1:CQM_FREQ_LSB] = st_r.ctrl.freq;
			end else if (PADDR == CQM_STAT_OFS) begin
				PRDATA[CQM_SAT_BIT] = st_r.sat_sticky;
				PRDATA[CQM_SLOT_BIT] = st_r.slot;
				PRDATA[CQM_PHASE_LSB+2:CQM_PHASE_LSB] = st_r.phase;
			end
		end
	end

	assign cos_c = cqm_cos8(st_r.phase);
	assign sin_raw = cqm_cos8(3'(st_r.phase - 3'h2));
	assign sin_c = (st_r.ctrl.neg && st_r.ctrl.mix) ? -sin_raw : sin_raw;

	// half rate flagged in complex mode
	assign COMPLEX_INVALID = st_r.ctrl.mix && (st_r.ctrl.freq == CQM_MOD_HALF);
	assign SAMPLE_READY = !st_r.slot;

	always_comb begin
		st_nxt = st_r;
		// control field bits five to one
		if (wr_ctrl) begin
			st_nxt.ctrl = ctrl_of(PWDATA);
		end
		if (st_r.ctrl.stuff_en) begin
			st_nxt.slot = !st_r.slot;
		end else begin
			st_nxt.slot = 1'b0;
		end
		if (!st_r.slot) begin
			st_nxt.phase = 3'(st_r.phase + cqm_step(st_r.ctrl.freq));
		end
		if (wr_ctrl) begin
			st_nxt.phase = CQM_PHASE_RST;
		end
		// sticky clamp flag, set beats clear
		if (wr_stat && PWDATA[CQM_SAT_BIT]) begin
			st_nxt.sat_sticky = 1'b0;
		end
		if (sat_pulse) begin
			st_nxt.sat_sticky = 1'b1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			st_r.ctrl <= ctrl_of(32'(CQM_CTRL_RST));
			st_r.phase <= CQM_PHASE_RST;
			st_r.slot <= 1'b0;
			st_r.sat_sticky <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// one complex stage drives both outputs
	cqm_cmul u_cmul (
		.clk(CLOCK),
		.rst(RESET),
		.in_s(SAMPLE_IN),
		.cos_c(cos_c),
		.sin_c(sin_c),
		.mix(st_r.ctrl.mix),
		.blank(st_r.slot),
		.out_s(SAMPLE_OUT),
		.sat(sat_pulse)
	);
endmodule : cqm_mod
`default_nettype wire

/* testbench/cqm_mod_monitor.sv */
// port checks of the complex quadrature modulator
`timescale 1ns/1ps
`default_nettype none
module cqm_mod_monitor
	import cqm_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire cqm_iq_s SAMPLE_IN,
	input wire logic SAMPLE_READY,
	input wire cqm_iq_s SAMPLE_OUT,
	input wire logic COMPLEX_INVALID
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);
	logic acc;
	logic wc;
	assign acc = PSEL && PENABLE;
	assign wc = acc && PWRITE && PADDR == CQM_CTRL_OFS;
	bad_addr_a:
		assert property (acc && PADDR != CQM_CTRL_OFS && PADDR != CQM_STAT_OFS
			|-> PSLVERR && PRDATA == 0) else $error("unmapped not refused");
	stuff_zero_a:
		assert property (!SAMPLE_READY |=> SAMPLE_OUT == '0) else $error("slot not midscale");
	half_inval_a:
		assert property (wc && PWDATA[2] && PWDATA[5:4] == 2'h1 |=> COMPLEX_INVALID)
			else $error("half rate mix not flagged");
	quad_valid_a:
		assert property (wc && PWDATA[5] |=> !COMPLEX_INVALID) else $error("false flag");
	pass_off_a:
		assert property (wc && PWDATA[5:3] == 3'h0 ##1 SAMPLE_READY
			|=> SAMPLE_OUT == $past(SAMPLE_IN)) else $error("no pass through");
	quad_pos_a:
		assert property (wc && PWDATA[5:0] == 6'h24 ##1 SAMPLE_READY ##1 SAMPLE_READY |=>
			SAMPLE_OUT.re == -$past(SAMPLE_IN.im) && SAMPLE_OUT.im == $past(SAMPLE_IN.re))
			else $error("pos");
	quad_neg_a:
		assert property (wc && PWDATA[5:0] == 6'h26 ##1 SAMPLE_READY ##1 SAMPLE_READY |=>
			SAMPLE_OUT.re == $past(SAMPLE_IN.im) && SAMPLE_OUT.im == -$past(SAMPLE_IN.re))
			else $error("neg");
	ready_run_a:
		assert property (wc && !PWDATA[3] |-> ##2 SAMPLE_READY [*4]) else $error("slot");
endmodule : cqm_mod_monitor
`default_nettype wire

/* testbench/cqm_src.sv */
// i/q sample source in front of the modulator
`timescale 1ns/1ps
`default_nettype none
module cqm_src
	import cqm_pkg::*;
(
	input wire logic clk,
	input wire logic cplx,
	input wire cqm_iq_s want,
	output cqm_iq_s smp
);
	function automatic logic signed [CQM_DW-1:0] lim(input logic signed [CQM_DW-1:0] v);
		return !cplx ? v : v > 14'sh16a0 ? 14'sh16a0 : v < -14'sh16a0 ? -14'sh16a0 : v;
	endfunction : lim
	initial smp = '0;
	always @(posedge clk) begin
		smp <= '{re: lim(want.re), im: lim(want.im)};
	end
endmodule : cqm_src
`default_nettype wire

/* testbench/cqm_mod_test.sv */
// self-checking bench of the complex quadrature modulator
`timescale 1ns/1ps
`default_nettype none
module cqm_mod_test import cqm_pkg::*;;
	logic CLOCK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, cplx = 0, se;
	logic [7:0] PADDR = '0;
	logic [31:0] PWDATA = '0, PRDATA;
	logic PREADY, PSLVERR, SAMPLE_READY, COMPLEX_INVALID;
	cqm_iq_s SAMPLE_IN, SAMPLE_OUT, want = '0;
	int err_count = 0, total_checks = 0;
	int cs[8] = '{16384, 11585, 0, -11585, -16384, -11585, 0, 11585};
	always #50 CLOCK = ~CLOCK;
	cqm_mod u_dut (.CLOCK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
		.PREADY, .PSLVERR, .SAMPLE_IN, .SAMPLE_READY, .SAMPLE_OUT, .COMPLEX_INVALID);
	cqm_src u_src (.clk(CLOCK), .cplx, .want, .smp(SAMPLE_IN));
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge CLOCK);
		PSEL <= 1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (PREADY !== 1'b1 && n < 16);
		if (PREADY !== 1'b1) begin
			err_count++;
			give_verdict;
		end else begin
			q = PRDATA;
			se = PSLVERR;
			PSEL <= 0;
			PENABLE <= 0;
		end
	endtask : apb
	function automatic int fit(input int v);
		int t;
		t = v >>> 14;
		return t > 8191 ? 8191 : t < -8192 ? -8192 : t;
	endfunction : fit
	task t_regs;
		logic [31:0] d;
		apb(1'b0, CQM_CTRL_OFS, 32'h0, d);
		chk("ctrl reset", d, 32'(CQM_CTRL_RST));
		apb(1'b1, CQM_CTRL_OFS, 32'hffffffff, d);
		apb(1'b0, CQM_CTRL_OFS, 32'h0, d);
		chk("ctrl bits", d, 32'h3e);
		apb(1'b1, 8'h10, 32'h1, d);
		chk("unmapped", {31'h0, se}, 32'h1);
		apb(1'b1, CQM_CTRL_OFS, 32'h0, d);
	endtask : t_regs
	task t_reset;
		logic [31:0] d;
		cplx <= 1'b1;
		apb(1'b1, CQM_CTRL_OFS, 32'h14, d);
		repeat (3) @(posedge CLOCK);
		chk("pre invalid", 32'(COMPLEX_INVALID), 32'h1);
		RESET <= 1'b1;
		repeat (2) @(posedge CLOCK);
		chk("reset out", 32'(SAMPLE_OUT), 32'h0);
		chk("reset ready", 32'(SAMPLE_READY), 32'h1);
		chk("reset invalid", 32'(COMPLEX_INVALID), 32'h0);
		RESET <= 1'b0;
		apb(1'b0, CQM_CTRL_OFS, 32'h0, d);
		chk("reset ctrl", d, 32'(CQM_CTRL_RST));
		apb(1'b0, CQM_STAT_OFS, 32'h0, d);
		chk("reset stat", d, 32'h0);
	endtask : t_reset
	task t_mode(input logic [5:0] cw, input int i, input int q);
		logic [31:0] d;
		logic r;
		int ph, p, c, s, re, im, sat;
		cplx <= cw[2];
		want <= '{re: 14'(i), im: 14'(q)};
		apb(1'b1, CQM_CTRL_OFS, 32'(cw), d);
		@(posedge CLOCK);
		chk("invalid", 32'(COMPLEX_INVALID), 32'(cw[2] && cw[5:4] == 2'h1));
		r = SAMPLE_READY;
		ph = 0;
		sat = 0;
		for (p = 0; p < 8; p++) begin
			@(posedge CLOCK);
			c = cs[ph];
			s = cw[2] ? (cw[1] ? -1 : 1) * cs[(ph + 6) % 8] : 0;
			re = i * c - q * s;
			im = i * s + q * c;
			if (r) sat |= fit(re) != re >>> 14 || fit(im) != im >>> 14;
			chk("out", 32'(SAMPLE_OUT), r ? {4'h0, 14'(fit(re)), 14'(fit(im))} : 32'h0);
			if (r) ph = (ph + (cw[5:4] == 3 ? 1 : cw[5:4] == 2 ? 2 : cw[5:4] == 1 ? 4 : 0)) % 8;
			chk("ready", 32'(SAMPLE_READY), 32'(cw[3] ? !r : 1'b1));
			r = SAMPLE_READY;
		end
		apb(1'b0, CQM_STAT_OFS, 32'h0, d);
		chk("sticky", 32'(d[0]), 32'(sat != 0));
		apb(1'b1, CQM_CTRL_OFS, 32'h0, d);
		apb(1'b1, CQM_STAT_OFS, 32'h1, d);
		apb(1'b0, CQM_STAT_OFS, 32'h0, d);
		chk("cleared", 32'(d[0]), 32'h0);
	endtask : t_mode
	initial begin
		repeat (10) @(posedge CLOCK);
		RESET <= 0;
		t_regs;
		t_mode(6'h24, 1000, -300);
		t_mode(6'h26, 1000, -300);
		t_mode(6'h34, 3000, 0);
		t_mode(6'h36, 0, 3000);
		t_mode(6'h14, 5000, 2000);
		t_mode(6'h10, -8192, 8191);
		t_mode(6'h38, 700, 900);
		t_mode(6'h30, 8191, -8192);
		t_mode(6'h0a, -5000, 4000);
		t_reset;
		give_verdict;
	end
endmodule : cqm_mod_test
bind cqm_mod cqm_mod_monitor u_mon (.CLOCK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
	.PRDATA, .PREADY, .PSLVERR, .SAMPLE_IN, .SAMPLE_READY, .SAMPLE_OUT, .COMPLEX_INVALID);
`default_nettype wire
